// file: core/ochv_top.sv
// Over-current flags and high-voltage input control with AXI4-Lite slave
//
// Operation
// - One interrupt enable per source: bits 6,5,4,0 port P, bit 2 supply.
// - Enable bit 0 masks the flag from the request; flag still records.
// - Detected over-current sets the flag at the enable's bit position.
// - Writing 1 clears a flag; writing 0 leaves it.
// - Level bits return synchronized pin when digital enabled and ADC off.
// - Level bit reads 1 otherwise, except under the test override.
// - Level register readable anytime; writes have no effect.
// - Analog mode defaults to weak pulldown; pull select 0 picks it.
// - Pullup only with pull select 1, test enable 1, not stopped.
// - Edge polarity 1 picks rising edge, 0 falling edge.
// - Bypass 1 powers down converter, only while direct connection set.
// - ADC link in run mode forces digital buffer off unless test enabled.
// - Test enable keeps buffer on in analog use in run; no stop effect.
// - Direct ADC connection keeps the digital buffer disabled always.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
module ochv_top
    import ochv_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [13:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [13:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [7:0]  overcurrent_detect,
    input  wire logic [1:0]  high_voltage_input,
    input  wire logic        stop_mode,
    output logic             overcurrent_irq,
    output logic [1:0]       hv_input_buffer_en,
    output logic [1:0]       hv_pullup_en,
    output logic [1:0]       hv_pulldown_en,
    output logic [1:0]       hv_edge_rising,
    output logic [1:0]       hv_converter_off,
    output logic [1:0]       hv_adc_link,
    output logic [1:0]       hv_adc_direct_out,
    output logic [1:0]       hv_pin_level
);
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0]  irq_enable_reg;
    logic [7:0]  event_flags_reg;
    logic [7:0]  pull_choice_reg;
    logic [7:0]  edge_choice_reg;
    logic [7:0]  bypass_ctrl_reg;
    logic [7:0]  input_ctrl_reg;
    logic [1:0]  hv_sync;
    logic [1:0]  dien;
    logic [1:0]  aen;
    logic [1:0]  tstn;
    logic [1:0]  dirc;
    logic [1:0]  level_bits;
    logic [1:0]  buf_on;
    logic [7:0]  oc_event;
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [13:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        wr_go;
    logic        wr_hit;
    logic [31:0] rd_word;
    logic        rd_hit;

    assign dien = input_ctrl_reg[OCHV_CTRL_DIEN +: 2];
    assign aen  = input_ctrl_reg[OCHV_CTRL_AEN +: 2];
    assign tstn = input_ctrl_reg[OCHV_CTRL_TE +: 2];
    assign dirc = input_ctrl_reg[OCHV_CTRL_DIR +: 2];
    assign oc_event = overcurrent_detect & OCHV_OC_MASK;

    // ------------------------------------------------------------------
    // Pin synchronisers and per-pin analog control
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_hv
            ochv_sync u_sync (
                .clk     (clk),
                .rst_n   (rst_n),
                .din     (high_voltage_input[gi]),
                .rst_val (1'b0),
                .dout    (hv_sync[gi])
            );
            assign buf_on[gi] = dirc[gi] & aen[gi] ? 1'b0 :
                                aen[gi] ? (stop_mode ? dien[gi]
                                                     : tstn[gi])
                                        : dien[gi];
            assign level_bits[gi] =
                ((dien[gi] & ~aen[gi]) |
                 (aen[gi] & tstn[gi] & ~dirc[gi] & ~stop_mode))
                ? hv_sync[gi] : 1'b1;
        end
    endgenerate

    // Outputs registered so the pads never see decode glitches
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hv_input_buffer_en <= 2'h0;
            hv_pullup_en       <= 2'h0;
            hv_pulldown_en     <= 2'h0;
            hv_edge_rising     <= 2'h0;
            hv_converter_off   <= 2'h0;
            hv_adc_link        <= 2'h0;
            hv_adc_direct_out  <= 2'h0;
            hv_pin_level       <= 2'h0;
        end
        else
        begin
            hv_input_buffer_en <= buf_on;
            hv_pullup_en <= aen & pull_choice_reg[1:0] & tstn &
                            {2{~stop_mode}};
            hv_pulldown_en <= aen & ~(pull_choice_reg[1:0] & tstn &
                                      {2{~stop_mode}});
            hv_edge_rising <= edge_choice_reg[1:0];
            hv_converter_off  <= bypass_ctrl_reg[1:0] & dirc & aen;
            hv_adc_link       <= aen;
            hv_adc_direct_out <= dirc & aen;
            hv_pin_level      <= level_bits;
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------------
    assign wr_go = (aw_held_reg | s_axi_awvalid) &
                   (w_held_reg | s_axi_wvalid) & ~s_axi_bvalid;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            awaddr_reg    <= '0;
            wdata_reg     <= '0;
            wstrb_reg     <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end
        else
        begin
            s_axi_awready <= ~aw_held_reg & ~s_axi_bvalid &
                             ~(s_axi_awvalid & s_axi_awready);
            s_axi_wready  <= ~w_held_reg & ~s_axi_bvalid &
                             ~(s_axi_wvalid & s_axi_wready);
            if (s_axi_awvalid & s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            if (aw_held_reg & w_held_reg)
            begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
            end
        end
    end

    always_comb
    begin
        case ({awaddr_reg[13:2], 2'b00})
            OCHV_ADDR_INPUT_LEVEL,
            OCHV_ADDR_IRQ_ENABLE,
            OCHV_ADDR_EVENT_FLAGS,
            OCHV_ADDR_PULL_CHOICE,
            OCHV_ADDR_EDGE_CHOICE,
            OCHV_ADDR_BYPASS_CTRL,
            OCHV_ADDR_INPUT_CTRL: wr_hit = 1'b1;
            default:              wr_hit = 1'b0;
        endcase
    end

    // Commit happens once both halves are held
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= OCHV_RESP_OKAY;
        end
        else if (aw_held_reg & w_held_reg)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? OCHV_RESP_OKAY : OCHV_RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    logic wr_commit;
    logic wr_lane0;
    assign wr_commit = aw_held_reg & w_held_reg;
    assign wr_lane0  = wr_commit & wstrb_reg[0];

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_enable_reg  <= OCHV_RST_BYTE;
            pull_choice_reg <= OCHV_RST_BYTE;
            edge_choice_reg <= OCHV_RST_BYTE;
            bypass_ctrl_reg <= OCHV_RST_BYTE;
            input_ctrl_reg  <= OCHV_RST_BYTE;
        end
        else if (wr_lane0)
        begin
            case ({awaddr_reg[13:2], 2'b00})
                OCHV_ADDR_IRQ_ENABLE:
                    irq_enable_reg <= wdata_reg[7:0] & OCHV_OC_MASK;
                OCHV_ADDR_PULL_CHOICE:
                    pull_choice_reg <= wdata_reg[7:0] & OCHV_HV_MASK;
                OCHV_ADDR_EDGE_CHOICE:
                    edge_choice_reg <= wdata_reg[7:0] & OCHV_HV_MASK;
                OCHV_ADDR_BYPASS_CTRL:
                    bypass_ctrl_reg <= wdata_reg[7:0] & OCHV_HV_MASK;
                OCHV_ADDR_INPUT_CTRL:
                    input_ctrl_reg <= wdata_reg[7:0] & 8'h55 |
                                      wdata_reg[7:0] & 8'hAA;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Over-current flags and request
    // ------------------------------------------------------------------
    logic [7:0] flag_clear;
    assign flag_clear = (wr_lane0 &&
                         {awaddr_reg[13:2], 2'b00} == OCHV_ADDR_EVENT_FLAGS)
                        ? wdata_reg[7:0] : 8'h00;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            event_flags_reg <= OCHV_RST_BYTE;
        else
            event_flags_reg <= (event_flags_reg & ~flag_clear) | oc_event;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            overcurrent_irq <= 1'b0;
        else
            overcurrent_irq <= |(event_flags_reg & irq_enable_reg);
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------------
    always_comb
    begin
        rd_hit  = 1'b1;
        rd_word = 32'h0000_0000;
        case ({s_axi_araddr[13:2], 2'b00})
            OCHV_ADDR_INPUT_LEVEL: rd_word[7:0] = {6'h00, level_bits};
            OCHV_ADDR_IRQ_ENABLE:  rd_word[7:0] = irq_enable_reg;
            OCHV_ADDR_EVENT_FLAGS: rd_word[7:0] = event_flags_reg;
            OCHV_ADDR_PULL_CHOICE: rd_word[7:0] = pull_choice_reg;
            OCHV_ADDR_EDGE_CHOICE: rd_word[7:0] = edge_choice_reg;
            OCHV_ADDR_BYPASS_CTRL: rd_word[7:0] = bypass_ctrl_reg;
            OCHV_ADDR_INPUT_CTRL:  rd_word[7:0] = input_ctrl_reg;
            default:               rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= OCHV_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= ~s_axi_rvalid &
                             ~(s_axi_arvalid & s_axi_arready);
            if (s_axi_arvalid & s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_hit ? OCHV_RESP_OKAY : OCHV_RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    logic unused_bits;
    assign unused_bits = wr_go ^ (|OCHV_IDX_INPUT_LEVEL);
endmodule : ochv_top

// file: core/ochv_pkg.sv
// Constants for the over-current and high-voltage input block
package ochv_pkg;
    // ------------------------------------------------------------------
    // Register byte addresses and the input level word index
    // ------------------------------------------------------------------
    localparam logic [11:0] OCHV_IDX_INPUT_LEVEL = 12'h331;
    localparam logic [13:0] OCHV_ADDR_INPUT_LEVEL = 14'h0CC4;
    localparam logic [13:0] OCHV_ADDR_IRQ_ENABLE  = 14'h0D00;
    localparam logic [13:0] OCHV_ADDR_EVENT_FLAGS = 14'h0D04;
    localparam logic [13:0] OCHV_ADDR_PULL_CHOICE = 14'h0D08;
    localparam logic [13:0] OCHV_ADDR_EDGE_CHOICE = 14'h0D0C;
    localparam logic [13:0] OCHV_ADDR_BYPASS_CTRL = 14'h0D10;
    localparam logic [13:0] OCHV_ADDR_INPUT_CTRL  = 14'h0D14;
    // ------------------------------------------------------------------
    // Field layouts and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] OCHV_OC_MASK   = 8'h75;
    localparam logic [7:0] OCHV_HV_MASK   = 8'h03;
    localparam logic [7:0] OCHV_RST_BYTE  = 8'h00;
    localparam int         OCHV_CTRL_DIEN = 0;
    localparam int         OCHV_CTRL_AEN  = 2;
    localparam int         OCHV_CTRL_TE   = 4;
    localparam int         OCHV_CTRL_DIR  = 6;
    localparam logic [1:0] OCHV_RESP_OKAY   = 2'h0;
    localparam logic [1:0] OCHV_RESP_SLVERR = 2'h2;
    localparam int         OCHV_SYNC_STAGES = 3;
endpackage : ochv_pkg

// file: core/ochv_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module ochv_sync
    import ochv_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic din,
    input  wire logic rst_val,
    output logic      dout
);
    logic [OCHV_SYNC_STAGES-1:0] stage_reg;

    // ------------------------------------------------------------------
    // Stages
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            stage_reg <= '0;
        else
            stage_reg <= {stage_reg[1:0], din};
    end

    // Stage 0 feeds stage 1 only; filter looks at stages 1 and 2
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            dout <= 1'b0;
        else if (stage_reg[1] == stage_reg[2])
            dout <= stage_reg[2];
    end

    // Reset value input kept for a uniform instance shape
    logic unused_rst_val;
    assign unused_rst_val = rst_val;
endmodule : ochv_sync

// file: dv/ochv_pins.sv
// Pin and detector model facing the over-current and input block
`timescale 1ns/1ps
module ochv_pins
(
    input  wire logic       clk,
    input  wire logic [7:0] oc_req,
    input  wire logic [1:0] pin_req,
    output logic      [7:0] overcurrent_detect,
    output logic      [1:0] high_voltage_input
);
    // Detectors pulse on the clock; pins are asynchronous levels
    always_ff @(posedge clk)
        overcurrent_detect <= oc_req;
    assign high_voltage_input = pin_req;
endmodule : ochv_pins

// file: dv/ochv_top_asserts.sv
// Port checks for the over-current and input block
`timescale 1ns/1ps
module ochv_top_asserts
    import ochv_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready,
    input wire logic       stop_mode,
    input wire logic       overcurrent_irq,
    input wire logic [1:0] hv_input_buffer_en,
    input wire logic [1:0] hv_pullup_en,
    input wire logic [1:0] hv_pulldown_en,
    input wire logic [1:0] hv_converter_off,
    input wire logic [1:0] hv_adc_link,
    input wire logic [1:0] hv_adc_direct_out,
    input wire logic [1:0] hv_pin_level
);
    // Outputs still hold reset values for a few edges after release
    logic [1:0] up_cnt_reg;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            up_cnt_reg <= 2'h0;
        else if (up_cnt_reg != 2'h3)
            up_cnt_reg <= up_cnt_reg + 2'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    chk_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
    chk_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |-> ##1 s_axi_rvalid)
        else $error("read answer late");
    chk_bresp_hold: assert property (
        $fell(s_axi_bvalid) |-> $past(s_axi_bready))
        else $error("bvalid dropped early");
    chk_rresp_hold: assert property (
        $fell(s_axi_rvalid) |-> $past(s_axi_rready))
        else $error("rvalid dropped early");
    chk_write_refused: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pends");
    chk_pull_exclusive: assert property (
        (hv_pullup_en & hv_pulldown_en) == 2'h0)
        else $error("pullup and pulldown together");
    chk_pullup_run: assert property (
        hv_pullup_en != 2'h0 |-> !$past(stop_mode))
        else $error("pullup in stop mode");
    chk_bypass_direct: assert property (
        (hv_converter_off & ~(hv_adc_direct_out & hv_adc_link)) == 2'h0)
        else $error("bypass without direct link");
    chk_buffer_direct: assert property (
        (hv_input_buffer_en & hv_adc_direct_out & hv_adc_link) == 2'h0)
        else $error("buffer on in direct mode");
    chk_level_default: assert property (
        up_cnt_reg == 2'h3 |-> (~hv_input_buffer_en
        & ~$past(hv_input_buffer_en) & ~hv_pin_level) == 2'h0)
        else $error("level low with buffer off");
    cov_irq: cover property (overcurrent_irq);
    cov_pullup: cover property (hv_pullup_en != 2'h0);
    cov_bypass: cover property (hv_converter_off == 2'h3);
endmodule : ochv_top_asserts

bind ochv_top ochv_top_asserts u_ochv_top_asserts (.clk, .rst_n,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .stop_mode, .overcurrent_irq,
    .hv_input_buffer_en, .hv_pullup_en, .hv_pulldown_en,
    .hv_converter_off, .hv_adc_link, .hv_adc_direct_out, .hv_pin_level);

// file: dv/tb.sv
// Self-checking bench for the over-current and input block
`timescale 1ns/1ps
module tb
    import ochv_pkg::*;
;
    logic        clk, rst_n, stop_mode, overcurrent_irq;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready;
    logic [13:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, high_voltage_input, pin_req;
    logic [1:0]  hv_input_buffer_en, hv_pullup_en, hv_pulldown_en;
    logic [1:0]  hv_edge_rising, hv_converter_off, hv_adc_link;
    logic [1:0]  hv_adc_direct_out, hv_pin_level;
    logic [7:0]  overcurrent_detect, oc_req;
    int          num_errors, check_count;
    logic [1:0]  last_bresp;

    ochv_top u_ochv_top (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .overcurrent_detect,
        .high_voltage_input, .stop_mode, .overcurrent_irq,
        .hv_input_buffer_en, .hv_pullup_en, .hv_pulldown_en,
        .hv_edge_rising, .hv_converter_off, .hv_adc_link,
        .hv_adc_direct_out, .hv_pin_level);
    ochv_pins u_ochv_pins (.clk, .oc_req, .pin_req, .overcurrent_detect,
        .high_voltage_input);

    always #25 clk = ~clk;
    // ------------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            num_errors++;
        end
    endtask : chk
    task automatic ck2(input logic [1:0] got, input logic [1:0] exp);
        chk({30'h0, got}, {30'h0, exp});
    endtask : ck2
    task automatic settle();
        repeat (3) @(posedge clk);
    endtask : settle
    // Each channel is released at the edge that takes it
    task automatic wr(input logic [13:0] a, input logic [7:0] d);
        logic aw;
        logic w;
        int   n;
        aw = 1'b1;
        w  = 1'b1;
        n  = 0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
            if (aw && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (w && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            aw = aw && !s_axi_awready;
            w  = w && !s_axi_wready;
        end while (!s_axi_bvalid && n < 100);
        last_bresp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n == 100)
            num_errors++;
        // One edge with bready low before the next write may raise it
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [13:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        logic ar;
        int   n;
        ar = 1'b1;
        n  = 0;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
            if (ar && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            ar = ar && !s_axi_arready;
        end while (!s_axi_rvalid && n < 100);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 100)
            num_errors++;
        // One edge with rready low before the next read may raise it
        @(posedge clk);
    endtask : rd
    task automatic rd_chk(input logic [13:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(d, exp);
    endtask : rd_chk
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0]  r;
        rd_chk(OCHV_ADDR_INPUT_LEVEL, 32'h3);
        rd_chk(OCHV_ADDR_IRQ_ENABLE, 32'h0);
        rd_chk(OCHV_ADDR_EVENT_FLAGS, 32'h0);
        rd_chk(OCHV_ADDR_PULL_CHOICE, 32'h0);
        rd(14'h0100, d, r);
        ck2(r, OCHV_RESP_SLVERR);
        wr(14'h0100, 8'h00);
        ck2(last_bresp, OCHV_RESP_SLVERR);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_ovc();
        oc_req <= 8'h77;
        @(posedge clk);
        oc_req <= 8'h00;
        settle();
        ck2({1'b0, overcurrent_irq}, 2'h0);
        rd_chk(OCHV_ADDR_EVENT_FLAGS, 32'h75);
        wr(OCHV_ADDR_IRQ_ENABLE, 8'hFF);
        ck2(last_bresp, OCHV_RESP_OKAY);
        rd_chk(OCHV_ADDR_IRQ_ENABLE, {24'h0, OCHV_OC_MASK});
        ck2({1'b0, overcurrent_irq}, 2'h1);
        wr(OCHV_ADDR_EVENT_FLAGS, 8'h00);
        rd_chk(OCHV_ADDR_EVENT_FLAGS, 32'h75);
        wr(OCHV_ADDR_IRQ_ENABLE, 8'h04);
        wr(OCHV_ADDR_EVENT_FLAGS, 8'h71);
        rd_chk(OCHV_ADDR_EVENT_FLAGS, 32'h04);
        ck2({1'b0, overcurrent_irq}, 2'h1);
        wr(OCHV_ADDR_EVENT_FLAGS, 8'h04);
        settle();
        ck2({1'b0, overcurrent_irq}, 2'h0);
        $display("t_ovc done");
    endtask : t_ovc
    task automatic t_level();
        wr(OCHV_ADDR_INPUT_CTRL, 8'h03);
        settle();
        ck2(hv_pin_level, 2'h2);
        rd_chk(OCHV_ADDR_INPUT_LEVEL, 32'h2);
        wr(OCHV_ADDR_INPUT_LEVEL, 8'h00);
        ck2(last_bresp, OCHV_RESP_OKAY);
        rd_chk(OCHV_ADDR_INPUT_LEVEL, 32'h2);
        wr(OCHV_ADDR_INPUT_CTRL, 8'h07);
        settle();
        ck2(hv_input_buffer_en, 2'h2);
        ck2(hv_pin_level, 2'h3);
        rd_chk(OCHV_ADDR_INPUT_LEVEL, 32'h3);
        wr(OCHV_ADDR_INPUT_CTRL, 8'h17);
        settle();
        ck2(hv_input_buffer_en, 2'h3);
        rd_chk(OCHV_ADDR_INPUT_LEVEL, 32'h2);
        stop_mode <= 1'b1;
        settle();
        rd_chk(OCHV_ADDR_INPUT_LEVEL, 32'h3);
        stop_mode <= 1'b0;
        wr(OCHV_ADDR_INPUT_CTRL, 8'h57);
        settle();
        ck2(hv_input_buffer_en, 2'h2);
        $display("t_level done");
    endtask : t_level
    task automatic t_pull();
        wr(OCHV_ADDR_PULL_CHOICE, 8'h01);
        wr(OCHV_ADDR_INPUT_CTRL, 8'h14);
        settle();
        ck2(hv_pullup_en, 2'h1);
        stop_mode <= 1'b1;
        settle();
        ck2(hv_pullup_en, 2'h0);
        ck2(hv_pulldown_en, 2'h1);
        stop_mode <= 1'b0;
        wr(OCHV_ADDR_PULL_CHOICE, 8'h00);
        settle();
        ck2(hv_pulldown_en, 2'h1);
        $display("t_pull done");
    endtask : t_pull
    task automatic t_edge_bypass();
        wr(OCHV_ADDR_EDGE_CHOICE, 8'h02);
        rd_chk(OCHV_ADDR_EDGE_CHOICE, 32'h2);
        ck2(hv_edge_rising, 2'h2);
        wr(OCHV_ADDR_BYPASS_CTRL, 8'h03);
        wr(OCHV_ADDR_INPUT_CTRL, 8'h0C);
        settle();
        ck2(hv_converter_off, 2'h0);
        ck2(hv_adc_direct_out, 2'h0);
        wr(OCHV_ADDR_INPUT_CTRL, 8'hCC);
        settle();
        ck2(hv_converter_off, 2'h3);
        ck2(hv_adc_link, 2'h3);
        ck2(hv_adc_direct_out, 2'h3);
        $display("t_edge_bypass done");
    endtask : t_edge_bypass
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize
    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial
    begin
        {clk, rst_n, stop_mode, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, oc_req} = '0;
        s_axi_wstrb = 4'hF;
        pin_req = 2'h2;
        num_errors = 0;
        check_count = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_ovc();
        t_level();
        t_pull();
        t_edge_bypass();
        summarize();
    end
    // Tests take well under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        summarize();
    end
endmodule : tb
